//--- design/fractional_divider_output_stage.sv
// Four steerable fractional dividers with phase stepping, feeding four output stages
//
// Contract
// - Divider ratio is integer part plus 43-bit fraction over two to the 43rd.
// - Each divider output feeds its output stages and the loop feedback dividers.
// - Phase request is signed picoseconds; negative advances edges, positive delays them.
// - Phase step raises or lowers frequency for a while, then restores it.
// - Rate fast, medium or slow trades deviation size against duration.
// - Successive phase requests accumulate without limit.
// - Stage 4 takes divider 4 or 5, stage 7 divider 6 or 7.
// - Dual stage holds two identical copies fed from one divider.
// - Each stage divides its divider clock by a 32-bit integer.
// - Default output has equal high and low time for even divide values; odd ones are high one tick longer.
// - Pulse mode high time is a 32-bit count of divider clocks.
// - Pulses are always high-going; with inversion set, the complementary output gives low-going pulses.
// - Complementary output has selectable inversion against the true output.
// - Duty adjustment works in every operating mode.
`timescale 1ns/1ps
module fractional_divider_output_stage #(
    parameter int STAGE_COPIES = 1
) (
    // Clock (stands in for the system PLL clock) and reset
    input wire logic clk,
    input wire logic rst_n,
    // Divider settings and phase step requests, index 0 is divider 4
    input wire fracdiv_pkg::div_cfg_s [fracdiv_pkg::NUM_DIV-1:0] div_cfg,
    input wire fracdiv_pkg::step_req_s [fracdiv_pkg::NUM_DIV-1:0] step_req,
    // Divider status
    output logic [fracdiv_pkg::NUM_DIV-1:0] step_busy,
    output logic [fracdiv_pkg::NUM_DIV-1:0][fracdiv_pkg::PEND_W-1:0] step_pending,
    // Divider clock ticks to the loop feedback dividers
    output logic [fracdiv_pkg::NUM_DIV-1:0] feedback_tick,
    // Output stage settings, index 0 is stage 4
    input wire fracdiv_pkg::stage_cfg_s [fracdiv_pkg::NUM_STAGE-1:0] stage_cfg,
    input wire logic stage4_source_select,
    input wire logic stage7_source_select,
    // Output pins
    output logic [fracdiv_pkg::NUM_STAGE-1:0][STAGE_COPIES-1:0] q,
    output logic [fracdiv_pkg::NUM_STAGE-1:0][STAGE_COPIES-1:0] complementary_output
);
    import fracdiv_pkg::*;

    if (INT_W < MIN_INT_W || FRAC_W != 43)
    begin : g_bad_width
        $error("divider ratio fields too narrow for the valid range");
    end

    // Single or dual stages only; the pin arrays are sized from this
    if (STAGE_COPIES < 1 || STAGE_COPIES > 2)
    begin : g_bad_copies
        $error("stage copies must be one or two");
    end

    // A request must fit the pending sum, or its sign would be lost
    if (STEP_W > PEND_W)
    begin : g_bad_step
        $error("pending phase narrower than a step request");
    end

    // Fast must move more per period than medium, medium more than slow
    if (STEP_PS_FAST <= STEP_PS_MEDIUM || STEP_PS_MEDIUM <= STEP_PS_SLOW)
    begin : g_bad_rates
        $error("phase step rates out of order");
    end

    // Registered divider ticks, one per divider
    logic [NUM_DIV-1:0] tick;

    ////////////////////////////////////////////////////////////////////////////
    // Steerable fractional dividers
    // Each one is a phase accumulator that adds one PLL cycle per clock
    for (genvar d = 0; d < NUM_DIV; d++)
    begin : g_div
        // Divider state and its next values
        logic [RATIO_W-1:0] ratio_ff;
        logic [1:0] rate_ff;
        logic [RATIO_W:0] resid_ff;
        logic signed [PEND_W-1:0] pend_ff;
        step_state_e state_ff;
        logic tick_ff;
        logic [RATIO_W:0] sum;
        logic [RATIO_W:0] eff_ratio;
        logic [PEND_W-1:0] pend_mag;
        logic [PEND_W-1:0] step_amt;
        logic [RATIO_W-1:0] delta;
        logic fire;
        logic signed [PEND_W-1:0] consumed;
        logic signed [PEND_W-1:0] nxt_pend;
        step_state_e nxt_state;

        // Size of this period's step: the rate limit, or the remainder if smaller
        // Clamping to the remainder keeps the last step from overshooting
        always_comb
        begin
            pend_mag = pend_ff[PEND_W-1] ? PEND_W'(-pend_ff) : PEND_W'(pend_ff);
            step_amt = step_ps_of(rate_ff);
            if (pend_mag < step_amt)
            begin
                step_amt = pend_mag;
            end
            delta = ratio_delta_of(step_amt);
        end

        // Shorter period advances edges, longer period delays them
        // The deviation lasts one period, so each period moves phase by delta only
        always_comb
        begin
            eff_ratio = {1'b0, ratio_ff};
            if (state_ff == STEP_RUN)
            begin
                if (pend_ff[PEND_W-1])
                begin
                    eff_ratio = {1'b0, ratio_ff} - {1'b0, delta};
                end
                else
                begin
                    eff_ratio = {1'b0, ratio_ff} + {1'b0, delta};
                end
            end
        end

        // Each clock adds one PLL cycle; a period ends when the ratio is reached
        // Fraction bits carry over in the residue, so the average period is exact
        assign sum = resid_ff + {1'b0, ONE_PLL_CYCLE};
        assign fire = (sum >= eff_ratio);

        // Residue keeps what is left over at each period end
        always_ff @(posedge clk)
        begin
            if (!rst_n)
            begin
                resid_ff <= '0;
            end
            else if (fire)
            begin
                resid_ff <= sum - eff_ratio;
            end
            else
            begin
                resid_ff <= sum;
            end
        end

        // Tick registered so stages and loop see a clean one-cycle pulse
        always_ff @(posedge clk)
        begin
            if (!rst_n)
            begin
                tick_ff <= 1'b0;
            end
            else
            begin
                tick_ff <= fire;
            end
        end

        // Ratio and rate reload only at a divider period boundary
        // Reloading mid-period would stretch or cut the period in flight
        always_ff @(posedge clk)
        begin
            if (!rst_n)
            begin
                ratio_ff <= RESET_RATIO;
                rate_ff <= RESET_RATE;
            end
            else if (fire)
            begin
                ratio_ff <= {div_cfg[d].int_part, div_cfg[d].frac};
                rate_ff <= div_cfg[d].rate;
            end
        end

        // Phase consumed this period, signed like the pending amount
        // Only a period that really ran at the changed ratio counts
        always_comb
        begin
            consumed = '0;
            if (fire && (state_ff == STEP_RUN))
            begin
                consumed = pend_ff[PEND_W-1] ? -$signed(step_amt) : $signed(step_amt);
            end
        end

        // New requests add to what is still pending, with no range limit
        // A request in the cycle of a period end sees both changes at once
        always_comb
        begin
            nxt_pend = pend_ff - consumed;
            if (step_req[d].valid)
            begin
                nxt_pend = nxt_pend + PEND_W'(step_req[d].ps);
            end
        end

        // Pending phase register
        always_ff @(posedge clk)
        begin
            if (!rst_n)
            begin
                pend_ff <= '0;
            end
            else
            begin
                pend_ff <= nxt_pend;
            end
        end

        // Step state: back to the programmed ratio once nothing is pending
        // Leaving on the next value avoids one extra stepped period
        always_comb
        begin
            case (state_ff)
                STEP_IDLE: nxt_state = (pend_ff != '0) ? STEP_RUN : STEP_IDLE;
                STEP_RUN: nxt_state = (nxt_pend == '0) ? STEP_IDLE : STEP_RUN;
                default: nxt_state = STEP_IDLE;
            endcase
        end

        // Step state register
        always_ff @(posedge clk)
        begin
            if (!rst_n)
            begin
                state_ff <= STEP_IDLE;
            end
            else
            begin
                state_ff <= nxt_state;
            end
        end

        // Status comes straight from registers
        assign tick[d] = tick_ff;
        assign step_busy[d] = (state_ff == STEP_RUN);
        assign step_pending[d] = pend_ff;
    end

    // Same divider clock goes to the loop feedback path
    // Phase steps reach the loop as well, so a closed loop may undo them
    assign feedback_tick = tick;

    ////////////////////////////////////////////////////////////////////////////
    // Output stages: 4 picks divider 4 or 5, 5 fixed to 5, 6 fixed to 6, 7 picks 6 or 7
    // Fixed stages tie their select low and see the same tick on both inputs
    // Stage 4 picks divider 4 or 5
    output_stage #(
        .COPIES(STAGE_COPIES)
    ) u_stage4 (
        .clk(clk),
        .rst_n(rst_n),
        .tick_a(tick[0]),
        .tick_b(tick[1]),
        .source_select(stage4_source_select),
        .cfg(stage_cfg[0]),
        .q(q[0]),
        .complementary_output(complementary_output[0])
    );

    // Stage 5 is fixed to divider 5
    output_stage #(
        .COPIES(STAGE_COPIES)
    ) u_stage5 (
        .clk(clk),
        .rst_n(rst_n),
        .tick_a(tick[1]),
        .tick_b(tick[1]),
        .source_select(1'b0),
        .cfg(stage_cfg[1]),
        .q(q[1]),
        .complementary_output(complementary_output[1])
    );

    // Stage 6 is fixed to divider 6
    output_stage #(
        .COPIES(STAGE_COPIES)
    ) u_stage6 (
        .clk(clk),
        .rst_n(rst_n),
        .tick_a(tick[2]),
        .tick_b(tick[2]),
        .source_select(1'b0),
        .cfg(stage_cfg[2]),
        .q(q[2]),
        .complementary_output(complementary_output[2])
    );

    // Stage 7 picks divider 6 or 7
    output_stage #(
        .COPIES(STAGE_COPIES)
    ) u_stage7 (
        .clk(clk),
        .rst_n(rst_n),
        .tick_a(tick[2]),
        .tick_b(tick[3]),
        .source_select(stage7_source_select),
        .cfg(stage_cfg[3]),
        .q(q[3]),
        .complementary_output(complementary_output[3])
    );

endmodule

//--- design/fracdiv_pkg.sv
// Shared constants, carriers and helpers for the fractional divider and output stages
package fracdiv_pkg;

    // Divider ratio layout: integer part above a 43-bit fraction over 2**43
    localparam int FRAC_W = 43;
    localparam int INT_W = 8;
    localparam int RATIO_W = INT_W + FRAC_W;
    localparam int MIN_INT_W = 5;

    // Output stage integer divider and high-pulse-width counts
    localparam int DIV_W = 32;
    localparam logic [DIV_W-1:0] MIN_OUT_DIV = 32'h0000_0002;
    localparam logic [DIV_W-1:0] AUTO_DUTY = 32'h0000_0000;

    // Fine phase step request and pending-phase widths, in picoseconds
    localparam int STEP_W = 24;
    localparam int PEND_W = 32;

    // Phase-step rate codes
    localparam logic [1:0] RATE_FAST = 2'h0;
    localparam logic [1:0] RATE_MEDIUM = 2'h1;
    localparam logic [1:0] RATE_SLOW = 2'h2;

    // Phase moved per divider period at each rate, picoseconds
    localparam int STEP_PS_FAST = 8;
    localparam int STEP_PS_MEDIUM = 4;
    localparam int STEP_PS_SLOW = 1;

    // The block clock stands in for the system PLL clock
    localparam int CLK_PERIOD_NS = 100;
    localparam int PLL_PERIOD_PS = CLK_PERIOD_NS * 1000;

    // Divider and stage counts; divider numbering starts at four
    localparam int NUM_DIV = 4;
    localparam int NUM_STAGE = 4;

    // One PLL cycle in ratio units, and the reset ratio (zero loads at first edge)
    localparam logic [RATIO_W-1:0] ONE_PLL_CYCLE = {8'h01, 43'h0};
    localparam logic [RATIO_W-1:0] RESET_RATIO = '0;
    localparam logic [1:0] RESET_RATE = 2'h1;

    typedef struct packed
    {
        logic [INT_W-1:0] int_part;
        logic [FRAC_W-1:0] frac;
        logic [1:0] rate;
    } div_cfg_s;

    typedef struct packed
    {
        logic [DIV_W-1:0] out_div;
        logic [DIV_W-1:0] high_width;
        logic invert;
    } stage_cfg_s;

    typedef struct packed
    {
        logic valid;
        logic signed [STEP_W-1:0] ps;
    } step_req_s;

    typedef enum logic [1:0]
    {
        STEP_IDLE = 2'b01,
        STEP_RUN = 2'b10
    } step_state_e;

    // Largest phase moved in one divider period for a rate code
    function automatic logic [PEND_W-1:0] step_ps_of(input logic [1:0] rate);
        logic [PEND_W-1:0] r;
        r = PEND_W'(STEP_PS_MEDIUM);
        case (rate)
            RATE_FAST: r = PEND_W'(STEP_PS_FAST);
            RATE_SLOW: r = PEND_W'(STEP_PS_SLOW);
            default: r = PEND_W'(STEP_PS_MEDIUM);
        endcase
        return r;
    endfunction

    // Ratio change that moves one divider period by ps picoseconds
    function automatic logic [RATIO_W-1:0] ratio_delta_of(input logic [PEND_W-1:0] ps);
        logic [95:0] wide;
        wide = ({64'h0, ps} << FRAC_W) / 96'(PLL_PERIOD_PS);
        return wide[RATIO_W-1:0];
    endfunction

endpackage

//--- design/output_stage.sv
// One output stage: source select, integer divider, pulse width, true and complementary pins
`timescale 1ns/1ps
module output_stage #(
    parameter int COPIES = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Divider ticks from the two possible sources
    input wire logic tick_a,
    input wire logic tick_b,
    input wire logic source_select,
    // Stage settings
    input wire fracdiv_pkg::stage_cfg_s cfg,
    // Output pins, one pair per copy
    output logic [COPIES-1:0] q,
    output logic [COPIES-1:0] complementary_output
);
    import fracdiv_pkg::*;

    if (COPIES < 1 || COPIES > 2)
    begin : g_bad_copies
        $error("output_stage supports one or two copies");
    end

    logic [DIV_W-1:0] cnt_ff;
    logic [DIV_W-1:0] div_ff;
    logic [DIV_W-1:0] high_ff;
    logic sel_ff;
    logic inv_ff;
    logic tick;
    logic boundary;
    logic [DIV_W-1:0] nxt_cnt;
    logic [DIV_W-1:0] cfg_div;
    logic [DIV_W-1:0] cfg_high;
    logic nxt_level;

    ////////////////////////////////////////////////////////////////////////////
    // Source tick and settings to load at the period boundary
    assign tick = sel_ff ? tick_b : tick_a;
    // Zero div_ff only after reset, so the first tick loads the settings
    assign boundary = tick && ((div_ff == '0) || (cnt_ff == div_ff - 32'h1));
    always_comb
    begin
        // Ratio one cannot be shown at tick level; it acts as two
        cfg_div = (cfg.out_div < MIN_OUT_DIV) ? MIN_OUT_DIV : cfg.out_div;
        if (cfg.high_width == AUTO_DUTY)
        begin
            cfg_high = cfg_div - (cfg_div >> 1);
        end
        else
        begin
            cfg_high = cfg.high_width;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Period counter
    always_comb
    begin
        nxt_cnt = cnt_ff;
        if (boundary)
        begin
            nxt_cnt = '0;
        end
        else if (tick)
        begin
            nxt_cnt = cnt_ff + 32'h1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cnt_ff <= '0;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
        end
    end

    // Settings change only between periods, never mid-pulse
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            div_ff <= '0;
            high_ff <= '0;
            sel_ff <= 1'b0;
            inv_ff <= 1'b0;
        end
        else if (boundary)
        begin
            div_ff <= cfg_div;
            high_ff <= cfg_high;
            sel_ff <= source_select;
            inv_ff <= cfg.invert;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pulse level: high for the first high_ff ticks of each period, always high-going
    assign nxt_level = boundary ? (cfg_high != '0) : (div_ff != '0) && (nxt_cnt < high_ff);

    // Identical copies, all driven from the same source and counter
    for (genvar c = 0; c < COPIES; c++)
    begin : g_copy
        always_ff @(posedge clk)
        begin
            if (!rst_n)
            begin
                q[c] <= 1'b0;
                complementary_output[c] <= 1'b0;
            end
            else
            begin
                q[c] <= nxt_level;
                // Inversion is what gives a low-going pulse
                complementary_output[c] <= nxt_level ^ (boundary ? cfg.invert : inv_ff);
            end
        end
    end

endmodule

//--- bench/fdos_receiver.sv
// Clock receiver model: measures high time and period of each observed pin in clk cycles
`timescale 1ns/1ps
module fdos_receiver (
    // Clock
    input wire logic clk,
    // Pins under observation
    input wire logic [3:0] pin,
    // Last complete high time, period and rising edge count per pin
    output logic [3:0][15:0] hi_len,
    output logic [3:0][15:0] per_len,
    output logic [3:0][7:0] rises
);
    logic [3:0][15:0] hi_run;
    logic [3:0][15:0] per_run;
    logic [3:0] last;

    ////////////////////////////////////////////////////////////////////////////////
    // Run lengths start from zero, so the first rising edge reports the partial period since start
    initial
    begin
        {hi_len, per_len, rises, hi_run, per_run, last} = '0;
    end

    // A rising edge closes a period, a falling edge closes a high time
    always @(posedge clk)
        for (int i = 0; i < 4; i++)
        begin
            last[i] <= pin[i];
            if (pin[i] && !last[i])
            begin
                per_len[i] <= per_run[i];
                per_run[i] <= 16'h0001;
                hi_run[i] <= 16'h0001;
                rises[i] <= rises[i] + 8'h01;
            end
            else
            begin
                per_run[i] <= per_run[i] + 16'h0001;
                hi_run[i] <= hi_run[i] + {15'h0, pin[i]};
            end
            if (!pin[i] && last[i])
                hi_len[i] <= hi_run[i];
        end
endmodule

//--- bench/fractional_divider_output_stage_properties.sv
// Checker for divider ticks, phase stepping and output pin relations
`timescale 1ns/1ps
module fdos_checker #(
    parameter int STAGE_COPIES = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Divider side
    input wire fracdiv_pkg::div_cfg_s [fracdiv_pkg::NUM_DIV-1:0] div_cfg,
    input wire fracdiv_pkg::step_req_s [fracdiv_pkg::NUM_DIV-1:0] step_req,
    input wire logic [fracdiv_pkg::NUM_DIV-1:0] step_busy,
    input wire logic [fracdiv_pkg::NUM_DIV-1:0][fracdiv_pkg::PEND_W-1:0] step_pending,
    input wire logic [fracdiv_pkg::NUM_DIV-1:0] feedback_tick,
    // Output pins
    input wire logic [fracdiv_pkg::NUM_STAGE-1:0][STAGE_COPIES-1:0] q,
    input wire logic [fracdiv_pkg::NUM_STAGE-1:0][STAGE_COPIES-1:0] complementary_output
);
    import fracdiv_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [7:0] gap_ff;
    logic [1:0] clean_ff;
    div_cfg_s cfg0_ff;
    logic copies_ok;

    ////////////////////////////////////////////////////////////////////////////////
    // Cycles since the last tick of divider 4
    always_ff @(posedge clk)
        if (!rst_n || feedback_tick[0])
            gap_ff <= 8'h01;
        else if (gap_ff != 8'hff)
            gap_ff <= gap_ff + 8'h01;

    // Quiet ticks since the last setting change or step; new ratios lag one period
    always_ff @(posedge clk)
    begin
        cfg0_ff <= div_cfg[0];
        if (!rst_n || step_busy[0] || step_req[0].valid || div_cfg[0] != cfg0_ff)
            clean_ff <= 2'h0;
        else if (feedback_tick[0] && clean_ff != 2'h3)
            clean_ff <= clean_ff + 2'h1;
    end

    // Every copy of a stage shows the same pins
    always_comb
    begin
        copies_ok = 1'b1;
        for (int k = 0; k < NUM_STAGE; k++)
            copies_ok &= (q[k] == {STAGE_COPIES{q[k][0]}})
                && (complementary_output[k] == {STAGE_COPIES{complementary_output[k][0]}});
    end

    sequence s_accept;
        step_req[0].valid && step_req[0].ps != '0 && !step_busy[0] && step_pending[0] == '0;
    endsequence
    sequence s_apply;
        step_pending[0] != '0 ##1 step_busy[0];
    endsequence

    ////////////////////////////////////////////////////////////////////////////////
    chk_tick_period:
    assert property (feedback_tick[0] && clean_ff == 2'h3 && div_cfg[0].frac == '0
        |-> gap_ff == div_cfg[0].int_part) else $error("divider period off its ratio");
    chk_tick_single:
    assert property ((feedback_tick & $past(feedback_tick)) == '0)
        else $error("feedback tick longer than one cycle");
    chk_busy_rise:
    assert property (s_accept |=> s_apply) else $error("step did not start");
    chk_pending_add:
    assert property (s_accept |=> step_pending[0] == PEND_W'($past(step_req[0].ps)))
        else $error("pending phase not the request");
    chk_busy_end:
    assert property (step_busy[0] && !step_req[0].valid ##1 step_pending[0] == '0
        |-> !step_busy[0]) else $error("busy held after step done");
    chk_step_bound:
    assert property ($changed(step_pending[0]) && !$past(step_req[0].valid)
        |-> step_pending[0] - $past(step_pending[0]) + 32'h8 <= 32'h10)
        else $error("phase moved too far in one period");
    chk_fixed_source:
    assert property ($changed(q[1][0]) |-> feedback_tick[1] || $past(feedback_tick[1]))
        else $error("stage 5 moved without divider 5");
    chk_invert_hold:
    assert property ($changed(complementary_output[0][0] ^ q[0][0]) |-> $rose(q[0][0]))
        else $error("inversion changed inside a period");
    chk_copies_same:
    assert property (copies_ok) else $error("stage copies differ");
endmodule

bind fractional_divider_output_stage fdos_checker #(.STAGE_COPIES(STAGE_COPIES)) fdos_checker_inst (
    .clk(clk), .rst_n(rst_n), .div_cfg(div_cfg), .step_req(step_req), .step_busy(step_busy),
    .step_pending(step_pending), .feedback_tick(feedback_tick), .q(q),
    .complementary_output(complementary_output));

//--- bench/test_fractional_divider_output_stage.sv
// Self-checking bench for the fractional dividers and output stages
`timescale 1ns/1ps
module test_fractional_divider_output_stage;
    import fracdiv_pkg::*;
    logic clk;
    logic rst_n;
    div_cfg_s [NUM_DIV-1:0] div_cfg;
    step_req_s [NUM_DIV-1:0] step_req;
    logic [NUM_DIV-1:0] step_busy;
    logic [NUM_DIV-1:0][PEND_W-1:0] step_pending;
    logic [NUM_DIV-1:0] feedback_tick;
    stage_cfg_s [NUM_STAGE-1:0] stage_cfg;
    logic stage4_source_select;
    logic stage7_source_select;
    logic [NUM_STAGE-1:0][1:0] q;
    logic [NUM_STAGE-1:0][1:0] complementary_output;
    logic [3:0][15:0] hi_len;
    logic [3:0][15:0] per_len;
    logic [3:0][7:0] rises;
    int bad_count;
    int cmp_count;
    int cycles;

    ////////////////////////////////////////////////////////////////////////////////
    // Dual stages so the copies are exercised too
    fractional_divider_output_stage #(.STAGE_COPIES(2)) fractional_divider_output_stage_inst (
        .clk(clk), .rst_n(rst_n), .div_cfg(div_cfg), .step_req(step_req),
        .step_busy(step_busy), .step_pending(step_pending), .feedback_tick(feedback_tick),
        .stage_cfg(stage_cfg), .stage4_source_select(stage4_source_select),
        .stage7_source_select(stage7_source_select), .q(q),
        .complementary_output(complementary_output));
    fdos_receiver fdos_receiver_inst (.clk(clk), .pin({q[3][0], q[2][0], q[1][0], q[0][0]}),
        .hi_len(hi_len), .per_len(per_len), .rises(rises));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic compare(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Waits three periods so a new setting has reached the pins, then measures
    task automatic check_stage(input int s, input logic [15:0] per, input logic [15:0] hi,
        input logic inv);
        logic [7:0] r0;
        int n;
        r0 = rises[s];
        n = 0;
        while (rises[s] - r0 < 8'h03 && n < 2000)
        begin
            @(negedge clk);
            n++;
        end
        compare({16'h0, per_len[s]}, {16'h0, per});
        compare({16'h0, hi_len[s]}, {16'h0, hi});
        compare({31'h0, complementary_output[s][0]}, {31'h0, q[s][0] ^ inv});
    endtask

    // One step on divider 4 at a given rate, counting the periods that move phase
    task automatic step_test(input logic [1:0] rate, input int ps, input int moves);
        logic [31:0] prev;
        int n;
        int ch;
        div_cfg[0].rate = rate;
        repeat (40) @(negedge clk);
        step_req[0] = '{1'b1, 24'(ps)};
        @(negedge clk);
        step_req[0].valid = 1'b0;
        compare(step_pending[0], 32'(ps));
        prev = step_pending[0];
        n = 0;
        ch = 0;
        do
        begin
            @(negedge clk);
            n++;
            if (step_pending[0] !== prev)
                ch++;
            prev = step_pending[0];
        end
        while (step_busy[0] !== 1'b0 && n < 5000);
        compare(32'(ch), 32'(moves));
        compare(step_pending[0], 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial
    begin
        clk = 1'b0;
        cycles = 0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            print_verdict;
        end
    end

    // Main sequence; ratios stay inside the valid range
    initial
    begin
        bad_count = 0;
        cmp_count = 0;
        rst_n = 1'b0;
        step_req = '0;
        stage4_source_select = 1'b0;
        stage7_source_select = 1'b0;
        div_cfg[0] = '{8'h10, 43'h0, RATE_FAST};
        div_cfg[1] = '{8'h0e, 43'h0, RATE_MEDIUM};
        div_cfg[2] = '{8'h14, 43'h0, RATE_MEDIUM};
        div_cfg[3] = '{8'h0d, 43'h400_0000_0000, RATE_SLOW};
        // Pulse widths stay below the divide values
        stage_cfg[0] = '{32'h4, 32'h0, 1'b0};
        stage_cfg[1] = '{32'h5, 32'h2, 1'b1};
        stage_cfg[2] = '{32'h3, 32'h0, 1'b0};
        stage_cfg[3] = '{32'h4, 32'h1, 1'b0};
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        check_stage(0, 16'd64, 16'd32, 1'b0);
        check_stage(1, 16'd70, 16'd28, 1'b1);
        check_stage(2, 16'd60, 16'd40, 1'b0);
        check_stage(3, 16'd80, 16'd20, 1'b0);
        $display("test 1 done");
        stage4_source_select = 1'b1;
        stage7_source_select = 1'b1;
        stage_cfg[0].invert = 1'b1;
        stage_cfg[1].high_width = 32'h0;
        stage_cfg[2].out_div = 32'h2;
        stage_cfg[3].high_width = 32'h0;
        check_stage(0, 16'd56, 16'd28, 1'b1);
        check_stage(1, 16'd70, 16'd42, 1'b1);
        check_stage(2, 16'd40, 16'd20, 1'b0);
        check_stage(3, 16'd54, 16'd27, 1'b0);
        $display("test 2 done");
        step_test(RATE_FAST, 20, 3);
        step_test(RATE_MEDIUM, -10, 3);
        step_test(RATE_SLOW, 5, 5);
        step_test(2'h3, 8, 2);
        // Two requests back to back add up before any period consumes them
        step_req[0] = '{1'b1, 24'(6)};
        @(negedge clk);
        step_req[0].ps = -24'sd2;
        @(negedge clk);
        step_req[0].valid = 1'b0;
        compare(step_pending[0], 32'h4);
        repeat (200) @(negedge clk);
        compare(step_pending[0], 32'h0);
        compare({28'h0, step_busy}, 32'h0);
        check_stage(0, 16'd56, 16'd28, 1'b1);
        $display("test 3 done");
        print_verdict;
    end
endmodule
